// ### src/acr_top.sv
// converter control, sequencing and result registers
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module acr_top
   import acr_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic      [31:0]       avs_readdata_out,
   output logic                   avs_waitrequest_out,
   // processor side
   input  wire logic              global_irq_enable_in,
   input  wire logic              irq_vector_ack_in,
   input  wire logic [6:0]        trigger_sources_in,
   output logic                   conv_irq_out,
   // converter core
   input  wire acr_core_sample_t  core_sample_in,
   output acr_core_ctrl_t         core_ctrl_out
);
   if (ADDR_W < 10) begin : g_chk
      $error("acr_top: ADDR_W must be at least 10");
   end

   // register state
   logic            en_ff, ate_ff, ie_ff, flag_ff;
   logic [2:0]      ps_ff;
   logic            bin_ff;
   logic [2:0]      cmp_ff;
   logic [2:0]      ts_ff;
   logic [1:0]      ref_ff;
   logic            lar_ff;
   logic [4:0]      chan_wr_ff;
   logic [4:0]      chan_app_ff;
   logic [9:0]      result_ff;
   logic            lock_ff;
   // sequencing state
   acr_conv_state_t state_ff;
   logic [6:0]      div_cnt_ff;
   logic [4:0]      tick_cnt_ff;
   logic            conv_first_ff;
   logic            first_pend_ff;
   logic            trig_prev_ff;
   // bus state
   logic            wait_ff;
   logic [31:0]     rdata_ff;
   logic            irq_ff;
   acr_core_ctrl_t  core_ctrl_ff;

   // bus decode
   logic       hit;
   logic [7:0] idx;
   logic [7:0] wdat;
   logic       wr_acc, rd_cap;
   logic       wr_a, wr_b, wr_is;
   logic       rd_lo, rd_hi;

   assign idx    = avs_address_in[9:2];
   assign hit    = (avs_address_in[1:0] == 2'b00) && ((avs_address_in >> 10) == '0);
   assign wdat   = avs_writedata_in[7:0];
   // writes land on the edge where waitrequest is seen low
   assign wr_acc = avs_write_in && !wait_ff && avs_byteenable_in[0] && hit;
   // read side effects at capture so lock and data agree
   assign rd_cap = avs_read_in && wait_ff && hit;
   assign wr_a   = wr_acc && (idx == IDX_CTRL_A);
   assign wr_b   = wr_acc && (idx == IDX_CTRL_B);
   assign wr_is  = wr_acc && (idx == IDX_INSEL);
   assign rd_lo  = rd_cap && (idx == IDX_RESULT_LO);
   assign rd_hi  = rd_cap && (idx == IDX_RESULT_HI);

   // sequencing terms
   logic       busy, en_next, sw_start, trig_sel, trig_edge;
   logic       adc_tick, done, start_now, first_now;
   logic [6:0] div_max;
   logic [4:0] target;
   acr_mux_t   mux_app;

   assign busy     = (state_ff == ST_CONV);
   assign en_next  = wr_a ? wdat[CA_EN] : en_ff;
   assign sw_start = wr_a && wdat[CA_START] && en_next;
   assign trig_sel = (ts_ff == TS_FREE) ? 1'b0 : trigger_sources_in[ts_ff - 3'h1];
   // free running never edges here, so switching to it is silent
   assign trig_edge = ate_ff && trig_sel && !trig_prev_ff;
   assign div_max  = (ps_ff <= 3'h1) ? 7'h01 : 7'((8'h01 << ps_ff) - 8'h01);
   // compare high side so a lowered divider never waits for a wrap
   assign adc_tick = en_ff && (div_cnt_ff >= div_max);
   assign target   = conv_first_ff ? FIRST_CONV_CYCLES : NORM_CONV_CYCLES;
   assign done     = busy && en_next && adc_tick && (tick_cnt_ff == target - 5'd1);
   assign first_now = first_pend_ff || (!en_ff && en_next);
   assign start_now = en_next && ((!busy && (sw_start || trig_edge))
                      || (done && ate_ff && ts_ff == TS_FREE));

   function automatic acr_mux_t decode_chan(input logic [4:0] code);
      acr_mux_t m;
      m = '0;
      if (code[4]) begin
         m.diff    = 1'b1;
         m.gain20  = code[0];
         m.pos_pin = PAIR_POS_TBL[{code[3:1], 2'b00} +: 4];
         m.neg_pin = m.pos_pin + 4'h1;
      end else if (code[3:0] < SE_PIN_COUNT) begin
         m.pos_pin = code[3:0];
      end else begin
         m.internal = 3'(code[3:0] - INT_CODE_BASE);
      end
      return m;
   endfunction : decode_chan

   assign mux_app = decode_chan(chan_app_ff);

   // converter clock prescaler
   always_ff @(posedge clk_in) begin
      if (srst_in || !en_ff || adc_tick) begin
         div_cnt_ff <= 7'h00;
      end else begin
         div_cnt_ff <= div_cnt_ff + 7'h01;
      end
   end

   // conversion state machine
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_ff      <= ST_IDLE;
         tick_cnt_ff   <= 5'd0;
         conv_first_ff <= 1'b0;
      end else if (start_now) begin
         state_ff      <= ST_CONV;
         tick_cnt_ff   <= 5'd0;
         conv_first_ff <= first_now;
      end else begin
         case (state_ff)
            ST_IDLE: tick_cnt_ff <= 5'd0;
            ST_CONV: begin
               if (!en_next || done) begin
                  state_ff <= ST_IDLE;
               end else if (adc_tick) begin
                  tick_cnt_ff <= tick_cnt_ff + 5'd1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // initialization pending after enabling
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         first_pend_ff <= 1'b0;
      end else if (start_now) begin
         first_pend_ff <= 1'b0;
      end else if (!en_ff && en_next) begin
         first_pend_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         trig_prev_ff <= 1'b0;
      end else begin
         trig_prev_ff <= trig_sel;
      end
   end

   // converter_control_a
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         en_ff  <= RST_CTRL_A[CA_EN];
         ate_ff <= RST_CTRL_A[CA_ATE];
         ie_ff  <= RST_CTRL_A[CA_IE];
         ps_ff  <= RST_CTRL_A[CA_PS_LO +: 3];
      end else if (wr_a) begin
         en_ff  <= wdat[CA_EN];
         ate_ff <= wdat[CA_ATE];
         ie_ff  <= wdat[CA_IE];
         ps_ff  <= wdat[CA_PS_LO +: 3];
      end
   end

   // done flag: a completion in the clearing cycle wins
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         flag_ff <= RST_CTRL_A[CA_FLAG];
      end else if (done) begin
         flag_ff <= 1'b1;
      end else if ((wr_a && wdat[CA_FLAG]) || irq_vector_ack_in) begin
         flag_ff <= 1'b0;
      end
   end

   // converter_control_b; reserved bit not stored
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         bin_ff <= RST_CTRL_B[CB_BIN];
         cmp_ff <= RST_CTRL_B[CB_CMP_LO +: 3];
         ts_ff  <= RST_CTRL_B[CB_TS_LO +: 3];
      end else if (wr_b) begin
         bin_ff <= wdat[CB_BIN];
         cmp_ff <= wdat[CB_CMP_LO +: 3];
         ts_ff  <= wdat[CB_TS_LO +: 3];
      end
   end

   // input_select_register
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ref_ff     <= RST_INSEL[IS_REF_LO +: 2];
         lar_ff     <= RST_INSEL[IS_LAR];
         chan_wr_ff <= RST_INSEL[IS_CH_LO +: 5];
      end else if (wr_is) begin
         ref_ff     <= wdat[IS_REF_LO +: 2];
         lar_ff     <= wdat[IS_LAR];
         chan_wr_ff <= wdat[IS_CH_LO +: 5];
      end
   end

   // channel seen by the core only moves between conversions
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         chan_app_ff <= RST_INSEL[IS_CH_LO +: 5];
      end else if (!busy || done) begin
         chan_app_ff <= chan_wr_ff;
      end
   end

   // result capture and read lock
   acr_core_sample_t smp;
   logic [9:0]       conv_val;
   assign smp = core_sample_in;
   always_comb begin
      if (bin_ff) begin
         conv_val = smp.value;
      end else if (mux_app.diff && smp.negative) begin
         conv_val = SAT_VALUE;
      end else begin
         conv_val = smp.value;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         result_ff <= RST_RESULT;
      end else if (done && !lock_ff) begin
         result_ff <= conv_val;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         lock_ff <= 1'b0;
      end else if (rd_hi) begin
         lock_ff <= 1'b0;
      end else if (rd_lo) begin
         lock_ff <= 1'b1;
      end
   end

   // read mux; alignment applied at read time
   logic [7:0] rd_val;
   always_comb begin
      rd_val = 8'h00;
      if (hit) begin
         case (idx)
            IDX_RESULT_LO: rd_val = lar_ff ? {result_ff[1:0], 6'h00}
                                           : result_ff[7:0];
            IDX_RESULT_HI: rd_val = lar_ff ? result_ff[9:2]
                                           : {6'h00, result_ff[9:8]};
            IDX_CTRL_A:    rd_val = {en_ff, busy, ate_ff, flag_ff,
                                     ie_ff, ps_ff};
            IDX_CTRL_B:    rd_val = {bin_ff, cmp_ff, 1'b0, ts_ff};
            IDX_INSEL:     rd_val = {ref_ff, lar_ff, chan_wr_ff};
            default:       rd_val = 8'h00;
         endcase
      end
   end

   // one wait cycle, then a one-cycle answer
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else if ((avs_read_in || avs_write_in) && wait_ff) begin
         wait_ff  <= 1'b0;
         rdata_ff <= {24'h00_0000, rd_val};
      end else begin
         wait_ff  <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= flag_ff && ie_ff && global_irq_enable_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         core_ctrl_ff <= '0;
      end else begin
         core_ctrl_ff.power   <= en_ff;
         core_ctrl_ff.start   <= start_now;
         core_ctrl_ff.first   <= start_now && first_now;
         core_ctrl_ff.bipolar <= bin_ff;
         core_ctrl_ff.mux     <= mux_app;
      end
   end

   assign avs_readdata_out    = rdata_ff;
   assign avs_waitrequest_out = wait_ff;
   assign conv_irq_out        = irq_ff;
   assign core_ctrl_out       = core_ctrl_ff;

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   property p_hold_chan;
      busy && !done |=> $stable(chan_app_ff);
   endproperty
   a_hold_chan: assert property (p_hold_chan) else $error("channel moved mid conversion");

   property p_abort;
      busy && !en_next |=> !busy ##1 !busy;
   endproperty
   a_abort: assert property (p_abort) else $error("conversion not aborted");

   property p_conv_len;
      done |-> tick_cnt_ff == (conv_first_ff ? FIRST_CONV_CYCLES - 5'd1 : NORM_CONV_CYCLES - 5'd1);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("wrong conversion length");

   property p_start_read;
      rd_cap && idx == IDX_CTRL_A |=> avs_readdata_out[6] == $past(busy);
   endproperty
   a_start_read: assert property (p_start_read) else $error("start bit not busy");

   property p_zero_start;
      !busy && wr_a && !wdat[CA_START] && !trig_edge |=> !busy;
   endproperty
   a_zero_start: assert property (p_zero_start) else $error("zero write started");

   property p_flag_set;
      done |=> flag_ff && (busy == $past(start_now));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_flag_clr;
      irq_vector_ack_in && !done |=> !flag_ff;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

   property p_irq;
      !(flag_ff && ie_ff && global_irq_enable_in) |=> !conv_irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("spurious interrupt");

   property p_tick_gap;
      adc_tick |=> !adc_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("prescaler below two");

   property p_lock;
      lock_ff && !rd_hi |=> $stable(result_ff);
   endproperty
   a_lock: assert property (p_lock) else $error("locked result changed");

   property p_sat;
      done && !lock_ff && !bin_ff && mux_app.diff && core_sample_in.negative
         |=> result_ff == SAT_VALUE;
   endproperty
   a_sat: assert property (p_sat) else $error("negative not saturated");

   property p_rsv;
      rd_cap && idx == IDX_CTRL_B |=> !avs_readdata_out[3];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit nonzero");

   property p_freerun;
      done && ate_ff && ts_ff == TS_FREE |=> busy ##1 (busy || !en_ff);
   endproperty
   a_freerun: assert property (p_freerun) else $error("free run stalled");

   property p_no_trig;
      !ate_ff && !busy && !(wr_a && wdat[CA_START]) |=> !busy;
   endproperty
   a_no_trig: assert property (p_no_trig) else $error("start without cause");
endmodule : acr_top
`default_nettype wire

// ### shared/acr_pkg.sv
// constants and carrier types of the converter control block
package acr_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_RESULT_LO = 8'h78;
   localparam logic [7:0] IDX_RESULT_HI = 8'h79;
   localparam logic [7:0] IDX_CTRL_A    = 8'h7A;
   localparam logic [7:0] IDX_CTRL_B    = 8'h7B;
   localparam logic [7:0] IDX_INSEL     = 8'h7C;
   // reset values
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_INSEL  = 8'h00;
   localparam logic [9:0] RST_RESULT = 10'h000;
   // converter_control_a fields
   localparam int CA_EN    = 7;
   localparam int CA_START = 6;
   localparam int CA_ATE   = 5;
   localparam int CA_FLAG  = 4;
   localparam int CA_IE    = 3;
   localparam int CA_PS_LO = 0;
   // converter_control_b fields
   localparam int CB_BIN   = 7;
   localparam int CB_CMP_LO = 4;
   localparam int CB_RSV   = 3;
   localparam int CB_TS_LO = 0;
   // input_select_register fields
   localparam int IS_REF_LO = 6;
   localparam int IS_LAR    = 5;
   localparam int IS_CH_LO  = 0;
   // conversion lengths in converter clock cycles
   localparam logic [4:0] FIRST_CONV_CYCLES = 5'd25;
   localparam logic [4:0] NORM_CONV_CYCLES  = 5'd13;
   // channel map
   localparam logic [3:0]  SE_PIN_COUNT  = 4'hB;
   localparam logic [3:0]  INT_CODE_BASE = 4'hA;
   localparam logic [31:0] PAIR_POS_TBL  = 32'h9865_4210;
   localparam logic [2:0]  TS_FREE       = 3'h0;
   localparam logic [9:0]  SAT_VALUE     = 10'h000;

   typedef enum logic {ST_IDLE, ST_CONV} acr_conv_state_t;

   // internal: 0 pin, 1 temperature, 2 bandgap, 3 quarter supply, 4 ground, 5 reserved
   typedef struct packed {
      logic       diff;
      logic       gain20;
      logic [3:0] pos_pin;
      logic [3:0] neg_pin;
      logic [2:0] internal;
   } acr_mux_t;

   typedef struct packed {
      logic       power;
      logic       start;
      logic       first;
      logic       bipolar;
      acr_mux_t   mux;
   } acr_core_ctrl_t;

   typedef struct packed {
      logic       negative;
      logic [9:0] value;
   } acr_core_sample_t;
endpackage : acr_pkg

// ### dv/acr_core_model.sv
// behavioural model of the multiplexer and converter core
`timescale 1ns/10ps
`default_nettype none
module acr_core_model
   import acr_pkg::*;
(
   // clock
   input  wire logic             clk_in,
   // control from the block
   input  wire acr_core_ctrl_t   core_ctrl_in,
   // value the bench wants converted
   input  wire logic [9:0]       value_in,
   input  wire logic             negative_in,
   // sample back to the block
   output var  acr_core_sample_t core_sample_out
);
   acr_core_sample_t held_ff;

   // latched on the start pulse, stable through the whole conversion
   // unpowered core gives no stable value, so toggle it
   always_ff @(posedge clk_in) begin
      if (core_ctrl_in.start) begin
         held_ff <= '{negative: negative_in & core_ctrl_in.mux.diff, value: value_in};
      end else if (!core_ctrl_in.power) begin
         held_ff <= ~held_ff;
      end
   end

   assign core_sample_out = held_ff;
endmodule : acr_core_model
`default_nettype wire

// ### dv/acr_top_tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module acr_top_tb_top
   import acr_pkg::*;
;
   localparam logic [9:0] A_LO = 10'h1E0;
   localparam logic [9:0] A_HI = 10'h1E4;
   localparam logic [9:0] A_CA = 10'h1E8;
   localparam logic [9:0] A_CB = 10'h1EC;
   localparam logic [9:0] A_IS = 10'h1F0;

   logic             clk_in;
   logic             srst_in;
   logic [9:0]       avs_address_in;
   logic             avs_read_in;
   logic             avs_write_in;
   logic [31:0]      avs_writedata_in;
   logic [3:0]       avs_byteenable_in;
   logic [31:0]      avs_readdata_out;
   logic             avs_waitrequest_out;
   logic             global_irq_enable_in;
   logic             irq_vector_ack_in;
   logic [6:0]       trigger_sources_in;
   logic             conv_irq_out;
   acr_core_sample_t core_sample_in;
   acr_core_ctrl_t   core_ctrl_out;
   logic [9:0]       core_val;
   logic             core_neg;
   logic [3:0]       be_sel;
   logic [8:0]       notes_q[$];
   logic [8:0]       note;
   int               cyc;
   int               n_starts;
   int               n_first;
   int               n_mismatch;
   int               n_compared;

   acr_top #(.ADDR_W(10)) i_acr_top (
      .clk_in(clk_in), .srst_in(srst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .global_irq_enable_in(global_irq_enable_in),
      .irq_vector_ack_in(irq_vector_ack_in), .trigger_sources_in(trigger_sources_in),
      .conv_irq_out(conv_irq_out), .core_sample_in(core_sample_in),
      .core_ctrl_out(core_ctrl_out));

   acr_core_model i_acr_core_model (
      .clk_in(clk_in), .core_ctrl_in(core_ctrl_out), .value_in(core_val),
      .negative_in(core_neg), .core_sample_out(core_sample_in));

   task automatic print_verdict;
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one avalon transfer; request held until waitrequest is seen low
   task automatic xfer(input logic [9:0] a, input logic w, input logic [7:0] d,
                       input logic [8:0] nt, output logic [7:0] q);
      @(posedge clk_in);
      if (!w) notes_q.push_back(nt);
      avs_address_in    <= a;
      avs_write_in      <= w;
      avs_read_in       <= !w;
      avs_writedata_in  <= {24'($urandom), d};
      avs_byteenable_in <= be_sel;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
      q = avs_readdata_out[7:0];
      avs_write_in <= 1'b0;
      avs_read_in  <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(a, 1'b1, d, 9'h000, q);
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      logic [7:0] q;
      xfer(a, 1'b0, 8'h00, {1'b1, e}, q);
   endtask : rd

   task automatic peek(input logic [9:0] a, output logic [7:0] q);
      xfer(a, 1'b0, 8'h00, 9'h000, q);
   endtask : peek

   task automatic wait_flag(input int t0, input int lo, input int hi);
      logic [7:0] d;
      d = 8'h00;
      while (d[CA_FLAG] !== 1'b1 && cyc - t0 < 3000) peek(A_CA, d);
      chk(32'(cyc - t0 >= lo && cyc - t0 <= hi), 32'h1);
   endtask : wait_flag

   task automatic conv(input logic [7:0] ca, input logic [9:0] v, input int lo, input int hi);
      int t0;
      int s0;
      core_val <= v;
      wr(A_CA, ca);
      t0 = cyc;
      s0 = n_starts;
      rd(A_CA, (ca & 8'hEF) | 8'h40);
      wait_flag(t0, lo, hi);
      chk(32'(n_starts - s0), 32'h1);
   endtask : conv

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // scoreboard side: oldest note against each completed read
   always @(posedge clk_in) begin
      if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && notes_q.size() > 0) begin
         note = notes_q.pop_front();
         if (note[8]) chk(avs_readdata_out, {24'h0, note[7:0]});
      end
      if (core_ctrl_out.start === 1'b1) n_starts++;
      if (core_ctrl_out.first === 1'b1) n_first++;
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial begin
      logic [9:0] v;
      logic [9:0] w;
      logic [3:0] p;
      acr_mux_t   m;
      int         n;
      srst_in = 1'b1;
      avs_address_in = 10'h000;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'hF;
      global_irq_enable_in = 1'b0;
      irq_vector_ack_in = 1'b0;
      trigger_sources_in = 7'h00;
      core_val = 10'h000;
      core_neg = 1'b0;
      be_sel = 4'hF;
      void'($urandom(32'h8103647b));
      repeat (5) @(posedge clk_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 5; i++) rd(A_LO + 10'(4 * i), 8'h00);
      rd(10'h200, 8'h00);
      rd(10'h1E9, 8'h00);
      wr(A_CB, 8'hFF);
      rd(A_CB, 8'hF7);
      be_sel = 4'hE;
      wr(A_CB, 8'h00);
      be_sel = 4'hF;
      rd(A_CB, 8'hF7);
      wr(A_CB, 8'h00);
      wr(A_IS, 8'h03);
      v = 10'($urandom);
      conv(8'hC0, v, 48, 58);
      chk(32'(n_first), 32'h1);
      rd(A_CA, 8'h90);
      rd(A_LO, v[7:0]);
      rd(A_HI, {6'h00, v[9:8]});
      wr(A_IS, 8'h23);
      rd(A_LO, {v[1:0], 6'h00});
      rd(A_HI, v[9:2]);
      wr(A_CA, 8'h90);
      rd(A_CA, 8'h80);
      for (int c = 0; c < 8; c++) begin
         n = (c < 2) ? 2 : (1 << c);
         v = 10'($urandom);
         conv(8'hD0 | 8'(c), v, 12 * n, 13 * n + 8);
         rd(A_LO, {v[1:0], 6'h00});
         rd(A_HI, v[9:2]);
      end
      // low byte read freezes both bytes until the high byte is read
      v = 10'($urandom);
      w = ~v;
      conv(8'hD1, v, 24, 34);
      rd(A_LO, {v[1:0], 6'h00});
      conv(8'hD1, w, 24, 34);
      rd(A_HI, v[9:2]);
      conv(8'hD1, w, 24, 34);
      rd(A_LO, {w[1:0], 6'h00});
      rd(A_HI, w[9:2]);
      wr(A_CA, 8'hD1);
      n = cyc;
      wr(A_IS, 8'h05);
      repeat (4) @(posedge clk_in);
      chk(32'(core_ctrl_out.mux.pos_pin), 32'h3);
      wait_flag(n, 24, 34);
      repeat (4) @(posedge clk_in);
      chk(32'(core_ctrl_out.mux.pos_pin), 32'h5);
      wr(A_CA, 8'hD1);
      repeat (8) @(posedge clk_in);
      wr(A_CA, 8'h11);
      rd(A_CA, 8'h01);
      chk(32'(core_ctrl_out.power), 32'h0);
      repeat (60) @(posedge clk_in);
      rd(A_CA, 8'h01);
      v = 10'($urandom);
      wr(A_CA, 8'h81);
      conv(8'hC1, v, 48, 58);
      chk(32'(n_first), 32'h2);
      rd(A_LO, v[7:0]);
      rd(A_HI, {6'h00, v[9:8]});
      n = n_starts;
      wr(A_CA, 8'hF1);
      repeat (200) @(posedge clk_in);
      chk(32'(n_starts - n >= 6), 32'h1);
      wr(A_CA, 8'h81);
      repeat (40) @(posedge clk_in);
      n = n_starts;
      wr(A_CB, 8'h03);
      trigger_sources_in <= 7'h04;
      repeat (40) @(posedge clk_in);
      trigger_sources_in <= 7'h00;
      wr(A_CA, 8'hB1);
      trigger_sources_in <= 7'h01;
      repeat (40) @(posedge clk_in);
      chk(32'(n_starts - n), 32'h0);
      trigger_sources_in <= 7'h05;
      repeat (60) @(posedge clk_in);
      chk(32'(n_starts - n), 32'h1);
      trigger_sources_in <= 7'h00;
      n = n_starts;
      wr(A_CB, 8'h00);
      repeat (60) @(posedge clk_in);
      chk(32'(n_starts - n), 32'h0);
      wr(A_CA, 8'h89);
      repeat (3) @(posedge clk_in);
      chk(32'(conv_irq_out), 32'h0);
      global_irq_enable_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk(32'(conv_irq_out), 32'h1);
      irq_vector_ack_in <= 1'b1;
      @(posedge clk_in);
      irq_vector_ack_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk(32'(conv_irq_out), 32'h0);
      rd(A_CA, 8'h89);
      wr(A_IS, 8'h10);
      core_neg <= 1'b1;
      conv(8'hD9, 10'h3F0, 24, 34);
      rd(A_LO, 8'h00);
      rd(A_HI, 8'h00);
      wr(A_CB, 8'h80);
      conv(8'hD9, 10'h3F0, 24, 34);
      rd(A_LO, 8'hF0);
      rd(A_HI, 8'h03);
      chk(32'(core_ctrl_out.bipolar), 32'h1);
      for (int c = 0; c < 32; c++) begin
         wr(A_IS, 8'(c));
         repeat (4) @(posedge clk_in);
         m = core_ctrl_out.mux;
         p = PAIR_POS_TBL[4 * (c[3:1]) +: 4];
         if (c < 11) chk(32'({m.diff, m.internal, m.pos_pin}), 32'(c));
         else if (c < 16) chk(32'({m.diff, m.internal}), 32'(c - 10));
         else chk(32'({m.diff, m.gain20, m.pos_pin, m.neg_pin}),
                  32'({1'b1, c[0], p, p + 4'h1}));
      end
      print_verdict();
   end
endmodule : acr_top_tb_top
`default_nettype wire
